/* File: design/jtp_tap.sv */
/*
  Test access port: controller, instruction register and data registers.
  Assumes pins arrive raw; tck is the link clock and is free while in use.
  Assumes power-on reset is delivered as rst_n on sys_clk.
*/
// Operation
// - Sixteen-state controller stepped by tms on tck
// - Power-on reset enters test-logic-reset
// - All shift paths move LSB first
// - Four-bit instruction register, LSB on exit
// - Instruction capture shifts out 0x01
// - Instruction latched in update-IR; test-logic-reset loads IDCODE
// - Instruction selects the data path
// - Shift-DR outputs captured parallel values
// - Data latches load only in update-DR
// - Exit and pause states do nothing
// - Update may go straight to scanning
// - Five high tms clocks force reset
// - No dedicated test reset pin
// - Unprogrammed fuse: port pins, controller reset
// - Enabled port: pull-ups, scan and programming
// - ID, bypass, scan, programming, debug chains
`timescale 1ns/1ps
`default_nettype none
module jtp_tap #(
  parameter int unsigned BSC_W = jtp_pkg::BSC_W,
  parameter int unsigned PRG_W = jtp_pkg::PRG_W,
  parameter int unsigned DBG_W = jtp_pkg::DBG_W,
  parameter logic [31:0] ID_CODE = jtp_pkg::ID_CODE
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Power-on reset, synchronous, active low
  input wire logic tck, // Test clock, link domain
  input wire logic tms, // Test mode select pin
  input wire logic tdi, // Test data in pin
  input wire logic test_port_enable_fuse, // Fuse programmed
  input wire logic test_port_disable_bit, // Core control register bit
  input wire logic [BSC_W-1:0] bsc_pins_in, // Pin levels for capture
  input wire logic [PRG_W-1:0] prg_status, // Programming status for capture
  input wire logic [DBG_W-1:0] dbg_status, // Debug status for capture
  output logic tdo, // Test data out
  output logic tdo_oe, // Test data out drive enable
  output logic tap_active, // Pins belong to the test port
  output logic pin_pullup_en, // Internal pull-ups on test pins
  output logic [BSC_W-1:0] bsc_update, // Boundary scan latch, sys domain
  output logic extest_en, // Boundary scan drives pins
  output logic [PRG_W-1:0] prg_update, // Programming latch, sys domain
  output logic [DBG_W-1:0] dbg_update // Debug latch, sys domain
);
  // ----------------------------------------------------------------
  // Enable in the system domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic ext;
    logic [BSC_W-1:0] bsc;
    logic [PRG_W-1:0] prg;
    logic [DBG_W-1:0] dbg;
  } jtp_sys_t;

  jtp_sys_t sys_ff;
  jtp_sys_t nxt_sys;

  // Link-side reset and enable arrive as levels through two flops
  logic en_tck;
  logic rstn_tck;
  logic [1:0] tck_sync;
  logic [1:0] tck_lvl;

  assign tck_lvl = {sys_ff.en, rst_n};

  jtp_sync #(.W(2)) u_to_tck (
    .clk(tck),
    .rst_n(1'b1),
    .d(tck_lvl),
    .q(tck_sync)
  );
  assign en_tck = tck_sync[1];
  assign rstn_tck = tck_sync[0];

  // ----------------------------------------------------------------
  // Capture inputs into the link domain
  // ----------------------------------------------------------------
  // Capture values come from the system side and are sampled on tck,
  // so they pass two tck flops first; they are levels held over a scan.
  localparam int unsigned CW = BSC_W + PRG_W + DBG_W;
  logic [CW-1:0] cap_lvl;
  logic [CW-1:0] cap_sync;

  assign cap_lvl = {bsc_pins_in, prg_status, dbg_status};

  jtp_sync #(.W(CW)) u_cap_to_tck (
    .clk(tck),
    .rst_n(1'b1),
    .d(cap_lvl),
    .q(cap_sync)
  );

  // ----------------------------------------------------------------
  // Link domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [jtp_pkg::IR_W-1:0] ir_sh;
    logic [jtp_pkg::IR_W-1:0] ir;
    logic [31:0] id_sh;
    logic byp;
    logic [BSC_W-1:0] bsc_sh;
    logic [PRG_W-1:0] prg_sh;
    logic [DBG_W-1:0] dbg_sh;
    logic [BSC_W-1:0] bsc_lat;
    logic [PRG_W-1:0] prg_lat;
    logic [DBG_W-1:0] dbg_lat;
    logic tdo;
    logic oe;
  } jtp_lnk_t;

  jtp_lnk_t lnk_ff;
  jtp_lnk_t nxt_lnk;
  jtp_pkg::jtp_state_t state;
  jtp_pkg::jtp_sel_t sel;
  logic hold_rst;

  // No trst pin: only power-on reset, the fuse, the disable bit and tms reach the controller
  assign hold_rst = !rstn_tck || !en_tck;

  jtp_fsm u_fsm (
    .tck(tck),
    .hold_rst(hold_rst),
    .tms(tms),
    .state(state)
  );

  function automatic jtp_pkg::jtp_sel_t decode(input logic [3:0] op);
    if (op == jtp_pkg::OP_IDCODE) begin
      decode = jtp_pkg::SEL_ID;
    end else if (op == jtp_pkg::OP_EXTEST || op == jtp_pkg::OP_SAMPLE) begin
      decode = jtp_pkg::SEL_BSC;
    end else if (op == jtp_pkg::OP_PROG) begin
      decode = jtp_pkg::SEL_PRG;
    end else if (op == jtp_pkg::OP_DBG0 || op == jtp_pkg::OP_DBG1 ||
                 op == jtp_pkg::OP_DBG2 || op == jtp_pkg::OP_DBG3) begin
      decode = jtp_pkg::SEL_DBG;
    end else begin
      decode = jtp_pkg::SEL_BYPASS;
    end
  endfunction

  assign sel = decode(lnk_ff.ir);

  always_comb begin
    nxt_lnk = lnk_ff;
    // Exit and pause states fall through with every register held
    case (state)
      jtp_pkg::ST_RESET: begin
        nxt_lnk.ir = jtp_pkg::OP_IDCODE;
      end
      jtp_pkg::ST_CAP_IR: begin
        nxt_lnk.ir_sh = jtp_pkg::IR_CAPTURE;
      end
      jtp_pkg::ST_SH_IR: begin
        nxt_lnk.ir_sh = {tdi, lnk_ff.ir_sh[jtp_pkg::IR_W-1:1]};
      end
      jtp_pkg::ST_UPD_IR: begin
        nxt_lnk.ir = lnk_ff.ir_sh;
      end
      jtp_pkg::ST_CAP_DR: begin
        nxt_lnk.id_sh = ID_CODE;
        nxt_lnk.byp = 1'b0;
        nxt_lnk.bsc_sh = cap_sync[CW-1 -: BSC_W];
        nxt_lnk.prg_sh = cap_sync[PRG_W+DBG_W-1 -: PRG_W];
        nxt_lnk.dbg_sh = cap_sync[DBG_W-1:0];
      end
      jtp_pkg::ST_SH_DR: begin
        case (sel)
          jtp_pkg::SEL_ID: nxt_lnk.id_sh = {tdi, lnk_ff.id_sh[31:1]};
          jtp_pkg::SEL_BSC: nxt_lnk.bsc_sh = {tdi, lnk_ff.bsc_sh[BSC_W-1:1]};
          jtp_pkg::SEL_PRG: nxt_lnk.prg_sh = {tdi, lnk_ff.prg_sh[PRG_W-1:1]};
          jtp_pkg::SEL_DBG: nxt_lnk.dbg_sh = {tdi, lnk_ff.dbg_sh[DBG_W-1:1]};
          default: nxt_lnk.byp = tdi;
        endcase
      end
      jtp_pkg::ST_UPD_DR: begin
        case (sel)
          jtp_pkg::SEL_BSC: nxt_lnk.bsc_lat = lnk_ff.bsc_sh;
          jtp_pkg::SEL_PRG: nxt_lnk.prg_lat = lnk_ff.prg_sh;
          jtp_pkg::SEL_DBG: nxt_lnk.dbg_lat = lnk_ff.dbg_sh;
          default: nxt_lnk.byp = lnk_ff.byp;
        endcase
      end
      default: nxt_lnk.byp = lnk_ff.byp;
    endcase
    // Output is retimed so tdo changes on the shifting edge itself, a clock after the bit reaches bit 0
    nxt_lnk.oe = ((state == jtp_pkg::ST_SH_IR) || (state == jtp_pkg::ST_SH_DR)) && en_tck;
    if (state == jtp_pkg::ST_SH_IR) begin
      nxt_lnk.tdo = lnk_ff.ir_sh[0];
    end else begin
      case (sel)
        jtp_pkg::SEL_ID: nxt_lnk.tdo = lnk_ff.id_sh[0];
        jtp_pkg::SEL_BSC: nxt_lnk.tdo = lnk_ff.bsc_sh[0];
        jtp_pkg::SEL_PRG: nxt_lnk.tdo = lnk_ff.prg_sh[0];
        jtp_pkg::SEL_DBG: nxt_lnk.tdo = lnk_ff.dbg_sh[0];
        default: nxt_lnk.tdo = lnk_ff.byp;
      endcase
    end
    if (!rstn_tck) begin
      nxt_lnk = '0;
      nxt_lnk.ir = jtp_pkg::OP_IDCODE;
    end
  end

  // Simple flop stage; a strict design would shift tdo on the falling edge
  always_ff @(posedge tck) begin
    lnk_ff <= nxt_lnk;
  end

  // ----------------------------------------------------------------
  // Latched outputs back to the system clock
  // ----------------------------------------------------------------
  // Latches change only in update-DR and then rest for many sys cycles,
  // so a per-bit level crossing is safe here.
  localparam int unsigned XW = BSC_W + PRG_W + DBG_W + 1;
  logic [XW-1:0] x_lvl;
  logic [XW-1:0] x_sync;

  assign x_lvl = {(lnk_ff.ir == jtp_pkg::OP_EXTEST), lnk_ff.bsc_lat,
                  lnk_ff.prg_lat, lnk_ff.dbg_lat};

  jtp_sync #(.W(XW)) u_to_sys (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(x_lvl),
    .q(x_sync)
  );

  always_comb begin
    nxt_sys.en = test_port_enable_fuse && !test_port_disable_bit;
    nxt_sys.ext = x_sync[XW-1] && sys_ff.en;
    nxt_sys.bsc = x_sync[XW-2 -: BSC_W];
    nxt_sys.prg = x_sync[PRG_W+DBG_W-1 -: PRG_W];
    nxt_sys.dbg = x_sync[DBG_W-1:0];
    if (!rst_n) begin
      nxt_sys = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    sys_ff <= nxt_sys;
  end

  assign tap_active = sys_ff.en;
  assign pin_pullup_en = sys_ff.en;
  assign extest_en = sys_ff.ext;
  assign bsc_update = sys_ff.bsc;
  assign prg_update = sys_ff.prg;
  assign dbg_update = sys_ff.dbg;
  assign tdo = lnk_ff.tdo;
  assign tdo_oe = lnk_ff.oe;
endmodule
`default_nettype wire

/* File: shared/jtp_pkg.sv */
/*
  Constants and types for the test access port block.
  Assumes a 4-bit instruction register and a standard 16-state controller.
*/
package jtp_pkg;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned IR_W = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam int unsigned ID_W = 32;
  localparam logic [31:0] ID_CODE = 32'h0000_0001; // Arbitrary neutral value
  localparam int unsigned BSC_W = 8;
  localparam int unsigned PRG_W = 16;
  localparam int unsigned DBG_W = 16;
  localparam int unsigned RST_TMS_HIGH = 5;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_IDCODE = 4'h1;
  localparam logic [3:0] OP_SAMPLE = 4'h2;
  localparam logic [3:0] OP_PROG = 4'h4;
  localparam logic [3:0] OP_DBG0 = 4'h8;
  localparam logic [3:0] OP_DBG1 = 4'h9;
  localparam logic [3:0] OP_DBG2 = 4'ha;
  localparam logic [3:0] OP_DBG3 = 4'hb;
  localparam logic [3:0] OP_BYPASS = 4'hf;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc, ST_PAU_IR = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf
  } jtp_state_t;

  typedef enum logic [2:0] {
    SEL_BYPASS = 3'h0, SEL_ID = 3'h1, SEL_BSC = 3'h2, SEL_PRG = 3'h3, SEL_DBG = 3'h4
  } jtp_sel_t;

  // Parallel latches crossing to the system clock
  typedef struct packed {
    logic [BSC_W-1:0] bsc;
    logic [PRG_W-1:0] prg;
    logic [DBG_W-1:0] dbg;
  } jtp_upd_t;

endpackage

/* File: design/jtp_sync.sv */
/*
  Two-flop level synchroniser.
  Assumes the input is a level stable for several destination cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module jtp_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [W-1:0] d, // Asynchronous level
  output logic [W-1:0] q // Synchronised level
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } jtp_sync_st_t;

  jtp_sync_st_t st_ff;
  jtp_sync_st_t nxt_st;

  always_comb begin
    nxt_st.meta = d;
    nxt_st.sync = st_ff.meta;
    if (!rst_n) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  assign q = st_ff.sync;
endmodule
`default_nettype wire

/* File: design/jtp_fsm.sv */
/*
  Sixteen-state test port controller, next-state function and state flop.
  Assumes tck is the link clock; reset is synchronous on tck.
*/
`timescale 1ns/1ps
`default_nettype none
module jtp_fsm (
  input wire logic tck, // Test clock
  input wire logic hold_rst, // Force test-logic-reset, synchronous to tck
  input wire logic tms, // Test mode select
  output jtp_pkg::jtp_state_t state // Present state
);
  jtp_pkg::jtp_state_t state_ff;
  jtp_pkg::jtp_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      jtp_pkg::ST_RESET: nxt_state = tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_IDLE: nxt_state = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_SEL_DR: nxt_state = tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
      jtp_pkg::ST_CAP_DR: nxt_state = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_SH_DR: nxt_state = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_EX1_DR: nxt_state = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAU_DR;
      jtp_pkg::ST_PAU_DR: nxt_state = tms ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PAU_DR;
      jtp_pkg::ST_EX2_DR: nxt_state = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_UPD_DR: nxt_state = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      // Reset entry from here is what makes five high clocks always suffice
      jtp_pkg::ST_SEL_IR: nxt_state = tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_CAP_IR;
      jtp_pkg::ST_CAP_IR: nxt_state = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_SH_IR: nxt_state = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_EX1_IR: nxt_state = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAU_IR;
      jtp_pkg::ST_PAU_IR: nxt_state = tms ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PAU_IR;
      jtp_pkg::ST_EX2_IR: nxt_state = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_UPD_IR: nxt_state = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      default: nxt_state = jtp_pkg::ST_RESET;
    endcase
    if (hold_rst) begin
      nxt_state = jtp_pkg::ST_RESET;
    end
  end

  always_ff @(posedge tck) begin
    state_ff <= nxt_state;
  end

  assign state = state_ff;
endmodule
`default_nettype wire

/* File: verification/jtp_tap_checker.sv */
/*
  Checker for the test port: pin ownership, drive enable, latch timing.
  Assumes it is bound to jtp_tap and sees that module's ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_checker #(
  parameter int unsigned BSC_W = 8,
  parameter int unsigned PRG_W = 16,
  parameter int unsigned DBG_W = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Power-on reset
  input wire logic tck, // Test clock
  input wire logic tms, // Test mode select
  input wire logic test_port_enable_fuse, // Fuse programmed
  input wire logic test_port_disable_bit, // Disable bit
  input wire logic tdo_oe, // Test data out enable
  input wire logic tap_active, // Pins owned by the port
  input wire logic pin_pullup_en, // Pull-ups on
  input wire logic extest_en, // Scan drives pins
  input wire logic [BSC_W-1:0] bsc_update, // Scan latch
  input wire logic [PRG_W-1:0] prg_update, // Programming latch
  input wire logic [DBG_W-1:0] dbg_update // Debug latch
);
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence s_port_on;
    (test_port_enable_fuse && !test_port_disable_bit) [*3];
  endsequence
  sequence s_tms_high;
    tms [*6];
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_pullup_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pin_pullup_en == tap_active) else $error("pull-up enable differs from ownership");
  a_port_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_port_on |-> tap_active) else $error("port not active while enabled");
  a_fuse_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!test_port_enable_fuse) [*3] |-> !tap_active) else $error("port active with fuse off");
  a_extest_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!tap_active) [*2] |-> !extest_en) else $error("pins driven by idle port");
  a_latch_still: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!tap_active) [*8] |-> $stable(bsc_update) && $stable(prg_update) && $stable(dbg_update))
    else $error("latch moved while port held in reset");
  // Fuse reaches the link through a sys flop and two tck flops, so count sys cycles
  a_oe_fuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!test_port_enable_fuse) [*3] |-> !tdo_oe) else $error("data out driven with fuse off");
  a_five_tms: assert property (@(posedge tck) disable iff (!rst_n)
    s_tms_high |-> !tdo_oe) else $error("data out driven after reset sequence");
  a_oe_shift: assert property (@(posedge tck) disable iff (!rst_n)
    $rose(tdo_oe) |-> !$past(tms, 2)) else $error("data out enabled outside a shift");
endmodule
bind jtp_tap jtp_tap_checker #(.BSC_W(BSC_W), .PRG_W(PRG_W), .DBG_W(DBG_W)) jtp_tap_checker_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms),
  .test_port_enable_fuse(test_port_enable_fuse), .test_port_disable_bit(test_port_disable_bit),
  .tdo_oe(tdo_oe), .tap_active(tap_active), .pin_pullup_en(pin_pullup_en),
  .extest_en(extest_en), .bsc_update(bsc_update), .prg_update(prg_update),
  .dbg_update(dbg_update));
`default_nettype wire

/* File: verification/jtp_host.sv */
/*
  Behavioural external test controller with scan tasks.
  Assumes each scan starts from run-test/idle.
*/
`timescale 1ns/1ps
`default_nettype none
module jtp_host (
  output logic tck, // Test clock
  output logic tms, // Test mode select
  output logic tdi, // Test data in
  input wire logic tdo // Test data out
);
  // Free running: the port needs clocks in reset to settle
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    forever #6 tck = ~tck;
  end
  // Outside shifts tdi toggles so a stale bit never passes for data
  task automatic walk(input logic m, input int k);
    repeat (k) begin
      @(posedge tck);
      tms <= m;
      tdi <= ~tdi;
    end
  endtask
  // Entry pattern of e edges, n shift bits, then 1,0 back to idle
  task automatic scan(input int e, input logic [3:0] ent, input int n,
                      input logic [63:0] din, output logic [63:0] dout);
    logic o;
    dout = '0;
    for (int j = 0; j < e + n + 3; j++) begin
      @(posedge tck);
      o = tdo;
      // tdo is launched by the shifting edge itself, so bit k is seen one edge later
      if (j >= e + 2 && j < e + n + 2) dout[j-e-2] = o;
      if (j < e) tms <= ent[j];
      else if (j < e + n) tms <= (j == e + n - 1);
      else tms <= (j == e + n);
      tdi <= (j >= e && j < e + n) ? din[j-e] : ~tdi;
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/jtag_tap_controller_tb_top.sv */
/*
  Bench top: system side stimulus, host model scans, chain model compares.
  Assumes the package's default chain widths.
*/
`timescale 1ns/1ps
`default_nettype none
module jtag_tap_controller_tb_top;
  logic sys_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, tap_active, pin_pullup_en, extest_en;
  logic test_port_enable_fuse, test_port_disable_bit;
  logic [jtp_pkg::BSC_W-1:0] bsc_pins_in, bsc_update;
  logic [jtp_pkg::PRG_W-1:0] prg_status, prg_update;
  logic [jtp_pkg::DBG_W-1:0] dbg_status, dbg_update;
  logic [63:0] dout, din, expv;
  int failures, comparisons, cycles;

  jtp_tap jtp_tap_i (.sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .test_port_enable_fuse(test_port_enable_fuse), .test_port_disable_bit(test_port_disable_bit),
    .bsc_pins_in(bsc_pins_in), .prg_status(prg_status), .dbg_status(dbg_status), .tdo(tdo),
    .tdo_oe(tdo_oe), .tap_active(tap_active), .pin_pullup_en(pin_pullup_en),
    .bsc_update(bsc_update), .extest_en(extest_en), .prg_update(prg_update),
    .dbg_update(dbg_update));
  jtp_host jtp_host_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end
  // ------------------------------------------------------------
  // Model and helpers
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic model(input logic [3:0] op, output int w, output logic [63:0] cap);
    w = 1;
    cap = 64'h0;
    case (op)
      jtp_pkg::OP_EXTEST, jtp_pkg::OP_SAMPLE: begin
        w = jtp_pkg::BSC_W;
        cap = 64'(bsc_pins_in);
      end
      jtp_pkg::OP_IDCODE: begin
        w = 32;
        cap = 64'(jtp_pkg::ID_CODE);
      end
      jtp_pkg::OP_PROG: begin
        w = jtp_pkg::PRG_W;
        cap = 64'(prg_status);
      end
      jtp_pkg::OP_DBG0, jtp_pkg::OP_DBG1, jtp_pkg::OP_DBG2, jtp_pkg::OP_DBG3: begin
        w = jtp_pkg::DBG_W;
        cap = 64'(dbg_status);
      end
      default: w = 1;
    endcase
  endtask
  task automatic run_op(input logic [3:0] op, input bit load);
    int w;
    logic [63:0] cap;
    @(posedge sys_clk);
    bsc_pins_in <= jtp_pkg::BSC_W'($urandom);
    prg_status <= jtp_pkg::PRG_W'($urandom);
    dbg_status <= jtp_pkg::DBG_W'($urandom);
    din = {$urandom, $urandom};
    @(posedge sys_clk);
    if (load) begin
      jtp_host_i.scan(4, 4'b0011, 4, {60'h0, op}, dout);
      check(dout, {60'h0, jtp_pkg::IR_CAPTURE});
    end
    model(op, w, cap);
    jtp_host_i.scan(3, 4'b0001, w + 4, din, dout);
    expv = (cap | (din << w)) & ((64'h1 << (w + 4)) - 64'h1);
    check(dout, expv);
    repeat (6) @(posedge sys_clk);
    expv = din >> 4;
    check({63'h0, extest_en}, {63'h0, op == jtp_pkg::OP_EXTEST});
    if (op == jtp_pkg::OP_EXTEST) check(64'(bsc_update), 64'(expv[jtp_pkg::BSC_W-1:0]));
    if (op == jtp_pkg::OP_PROG) check(64'(prg_update), 64'(expv[jtp_pkg::PRG_W-1:0]));
    if (op[3:2] == 2'b10) check(64'(dbg_update), 64'(expv[jtp_pkg::DBG_W-1:0]));
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(52746));
    rst_n = 1'b0;
    test_port_enable_fuse = 1'b1;
    test_port_disable_bit = 1'b0;
    bsc_pins_in = '0;
    prg_status = '0;
    dbg_status = '0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check({63'h0, tap_active}, 64'h1);
    check({63'h0, pin_pullup_en}, 64'h1);
    jtp_host_i.walk(1'b0, 1);
    run_op(jtp_pkg::OP_IDCODE, 1'b0);
    for (int op = 0; op < 16; op++) run_op(4'(op), 1'b1);
    // Park in pause-DR, then five high clocks must restore the reset instruction
    jtp_host_i.walk(1'b1, 1);
    jtp_host_i.walk(1'b0, 2);
    jtp_host_i.walk(1'b1, 1);
    jtp_host_i.walk(1'b0, 2);
    jtp_host_i.walk(1'b1, 5);
    jtp_host_i.walk(1'b0, 1);
    run_op(jtp_pkg::OP_IDCODE, 1'b0);
    @(posedge sys_clk);
    test_port_enable_fuse <= 1'b0;
    jtp_host_i.scan(4, 4'b0011, 4, 64'hf, dout);
    repeat (2) @(posedge sys_clk);
    check({63'h0, tap_active}, 64'h0);
    check({63'h0, pin_pullup_en}, 64'h0);
    test_port_enable_fuse <= 1'b1;
    test_port_disable_bit <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check({63'h0, tap_active}, 64'h0);
    test_port_disable_bit <= 1'b0;
    repeat (6) @(posedge sys_clk);
    jtp_host_i.walk(1'b0, 1);
    run_op(jtp_pkg::OP_IDCODE, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
